//--- core/lsc_pkg.sv
// package of constants and types for the supply control block
// Functional notes
// - six written bits steer the main controls
// - read returns flags plus echoed settings
// - enable low holds power, voltage and compensation off; static clamp follows its own bit
// - voltage select picks 13 or 18 V
// - line compensation bit raises selected level
// - flags stay low without any failure
// - pulsed overload: output off, flag set
// - on interval one tenth, cycle repeats
// - clean on interval clears overload flag
// - static clamp: flag follows overload only
// - over-temperature shuts the power output only, sets flag
// - pull-down active only while tone runs
// - tone path on by pin or bit
// - tone gate input keys the carrier
// - start half cycle, stop one cycle later
// - continuous bit keeps tone running while the tone path is on
`default_nettype none
package lsc_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned T_OFF_MS = 900;
   localparam int unsigned T_ON_MS = 90;
   localparam int unsigned T_OFF_CYC = T_OFF_MS * (CLK_HZ / 1000);
   localparam int unsigned T_ON_CYC = T_ON_MS * (CLK_HZ / 1000);
   localparam int unsigned TONE_HZ = 22000;
   // half tone period, rounded down
   localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
   localparam int TMR_W = 25;
   localparam int TONE_W = 10;
   // bus map
   localparam logic [3:0] SYSREG_OFS = 4'h0;
   localparam logic [7:0] SYSREG_RST = 8'h00;
   // written field positions
   localparam int WB_EN = 0;
   localparam int WB_VOLTAGE_SELECT_BIT = 1;
   localparam int WB_LLC = 2;
   localparam int WB_PCL = 3;
   localparam int WB_TTX = 4;
   localparam int WB_TEN = 5;
   // read field positions, bits 7..5 are test bits and read zero
   localparam int RB_EN = 0;
   localparam int RB_VOLTAGE_SELECT_BIT = 1;
   localparam int RB_LLC = 2;
   localparam int RB_OLF = 3;
   localparam int RB_OTF = 4;

   typedef struct packed {
      logic continuous_tone_bit;
      logic tone_path_bit;
      logic pulsed_limit_bit;
      logic line_drop_comp_bit;
      logic voltage_select_bit;
      logic enable_bit;
   } lsc_ctrl_s;

   typedef struct packed {
      logic power_on;
      logic volt_high;
      logic line_comp;
      logic static_clamp;
   } lsc_power_s;

   typedef enum logic [1:0] {
      OL_NORMAL = 2'h0,
      OL_OFF = 2'h1,
      OL_ON = 2'h3
   } lsc_ol_e;

   typedef enum logic [1:0] {
      TG_IDLE = 2'h0,
      TG_START = 2'h1,
      TG_RUN = 2'h3,
      TG_STOP = 2'h2
   } lsc_tone_e;
endpackage
`default_nettype wire

//--- core/lsc_supply_ctrl.sv
// supply control, protection sequencing and tone gating
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`default_nettype none
module lsc_supply_ctrl #(
   parameter int unsigned OFF_CYC = lsc_pkg::T_OFF_CYC,
   parameter int unsigned ON_CYC = lsc_pkg::T_ON_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic OVERLOAD_DET,
   input wire logic OVER_TEMP_DET,
   input wire logic TONE_GATE_INPUT,
   input wire logic TONE_PATH_ENABLE,
   output lsc_pkg::lsc_power_s POWER,
   output logic TONE_PATH_ON,
   output logic TONE_OUT,
   output logic PULLDOWN_CONTROL_OUT
);
   localparam int NSYNC = 4;
   localparam logic [lsc_pkg::TMR_W-1:0] OFF_LOAD =
      lsc_pkg::TMR_W'(OFF_CYC - 1);
   localparam logic [lsc_pkg::TMR_W-1:0] ON_LOAD =
      lsc_pkg::TMR_W'(ON_CYC - 1);
   localparam logic [lsc_pkg::TONE_W-1:0] HALF_LOAD =
      lsc_pkg::TONE_W'(lsc_pkg::TONE_HALF_CYC - 1);

   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic overload_s;
   logic over_temp_s;
   logic gate_s;
   logic path_pin_s;

   lsc_pkg::lsc_ctrl_s ctrl_q;
   logic ack_q;
   logic req;
   logic hit;
   logic [7:0] sysreg_rd;

   lsc_pkg::lsc_ol_e ol_q;
   logic [lsc_pkg::TMR_W-1:0] tmr_q;
   logic tmr_zero;
   logic seen_q;
   logic olf_q;
   logic otf_q;

   lsc_pkg::lsc_tone_e tg_q;
   logic [lsc_pkg::TONE_W-1:0] half_q;
   logic [1:0] halves_q;
   logic half_tick;
   logic tone_req;
   logic tone_gen;
   logic tone_q;
   logic path_on;

   // pin inputs come from the analog side and, for the tone pins, the host; all are asynchronous to CLK
   assign pin_raw = {TONE_PATH_ENABLE, TONE_GATE_INPUT,
                     OVER_TEMP_DET, OVERLOAD_DET};

   // two-stage synchroniser per pin
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (RST) begin
               sync1_q[i] <= 1'b0;
               sync2_q[i] <= 1'b0;
            end else if (CE) begin
               sync1_q[i] <= pin_raw[i];
               sync2_q[i] <= sync1_q[i];
            end
         end
      end
   endgenerate

   assign overload_s = sync2_q[0];
   assign over_temp_s = sync2_q[1];
   assign gate_s = sync2_q[2];
   assign path_pin_s = sync2_q[3];

   // ------------------------------------------------------------
   // avalon slave: one wait state on every access
   // ------------------------------------------------------------
   assign req = AVS_READ | AVS_WRITE;
   assign hit = (AVS_ADDRESS == lsc_pkg::SYSREG_OFS);
   assign AVS_WAITREQUEST = req & ~ack_q;

   // ack pulses for one cycle so each request takes exactly two edges
   always_ff @(posedge CLK) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else if (CE) begin
         ack_q <= req & ~ack_q;
      end
   end

   // read image: echoes and flags, test bits forced low
   always_comb begin
      sysreg_rd = 8'h00;
      sysreg_rd[lsc_pkg::RB_EN] = ctrl_q.enable_bit;
      sysreg_rd[lsc_pkg::RB_VOLTAGE_SELECT_BIT] = ctrl_q.voltage_select_bit;
      sysreg_rd[lsc_pkg::RB_LLC] = ctrl_q.line_drop_comp_bit;
      sysreg_rd[lsc_pkg::RB_OLF] = olf_q;
      sysreg_rd[lsc_pkg::RB_OTF] = otf_q;
   end

   // read data registered in the wait cycle, zero for unmapped
   always_ff @(posedge CLK) begin
      if (RST) begin
         AVS_READDATA <= 32'h00000000;
      end else if (CE) begin
         if (AVS_READ & ~ack_q) begin
            AVS_READDATA <= hit ? {24'h000000, sysreg_rd} : 32'h00000000;
         end
      end
   end

   // write lands on the edge that sees waitrequest low
   // test bits 7..6 are dropped, so a stray one cannot upset anything
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl_q <= lsc_pkg::lsc_ctrl_s'(lsc_pkg::SYSREG_RST[5:0]);
      end else if (CE) begin
         if (AVS_WRITE & ack_q & hit & AVS_BYTEENABLE[0]) begin
            ctrl_q.enable_bit <= AVS_WRITEDATA[lsc_pkg::WB_EN];
            ctrl_q.voltage_select_bit <= AVS_WRITEDATA[lsc_pkg::WB_VOLTAGE_SELECT_BIT];
            ctrl_q.line_drop_comp_bit <= AVS_WRITEDATA[lsc_pkg::WB_LLC];
            ctrl_q.pulsed_limit_bit <= AVS_WRITEDATA[lsc_pkg::WB_PCL];
            ctrl_q.tone_path_bit <= AVS_WRITEDATA[lsc_pkg::WB_TTX];
            ctrl_q.continuous_tone_bit <= AVS_WRITEDATA[lsc_pkg::WB_TEN];
         end
      end
   end

   // ------------------------------------------------------------
   // over-temperature: comparator carries its own hysteresis
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         otf_q <= 1'b0;
      end else if (CE) begin
         otf_q <= over_temp_s;
      end
   end

   // ------------------------------------------------------------
   // overload protection
   // ------------------------------------------------------------
   assign tmr_zero = (tmr_q == '0);

   // pulsed mode sequencer; static mode or stand-by parks it
   always_ff @(posedge CLK) begin
      if (RST) begin
         ol_q <= lsc_pkg::OL_NORMAL;
      end else if (CE) begin
         if (ctrl_q.pulsed_limit_bit | ~ctrl_q.enable_bit) begin
            ol_q <= lsc_pkg::OL_NORMAL;
         end else begin
            unique case (ol_q)
               lsc_pkg::OL_NORMAL: begin
                  if (overload_s & ~otf_q) begin
                     ol_q <= lsc_pkg::OL_OFF;
                  end
               end
               lsc_pkg::OL_OFF: begin
                  if (tmr_zero) begin
                     ol_q <= lsc_pkg::OL_ON;
                  end
               end
               lsc_pkg::OL_ON: begin
                  if (tmr_zero) begin
                     // any overload in the window restarts the cycle
                     ol_q <= (seen_q | overload_s) ? lsc_pkg::OL_OFF
                                                   : lsc_pkg::OL_NORMAL;
                  end
               end
               default: ol_q <= lsc_pkg::OL_NORMAL;
            endcase
         end
      end
   end

   // interval timer, reloaded on every entry to an interval
   always_ff @(posedge CLK) begin
      if (RST) begin
         tmr_q <= '0;
      end else if (CE) begin
         if (ctrl_q.pulsed_limit_bit | ~ctrl_q.enable_bit) begin
            tmr_q <= '0;
         end else if (ol_q == lsc_pkg::OL_NORMAL) begin
            tmr_q <= OFF_LOAD;
         end else if (tmr_zero) begin
            // off ends into on, on ends into off again if needed
            tmr_q <= (ol_q == lsc_pkg::OL_OFF) ? ON_LOAD : OFF_LOAD;
         end else begin
            tmr_q <= tmr_q - 1'b1;
         end
      end
   end

   // remembers any overload seen during the on window
   always_ff @(posedge CLK) begin
      if (RST) begin
         seen_q <= 1'b0;
      end else if (CE) begin
         if (ol_q != lsc_pkg::OL_ON) begin
            seen_q <= 1'b0;
         end else if (overload_s) begin
            seen_q <= 1'b1;
         end
      end
   end

   // overload flag: sticky through pulsed cycling, live when static
   always_ff @(posedge CLK) begin
      if (RST) begin
         olf_q <= 1'b0;
      end else if (CE) begin
         if (~ctrl_q.enable_bit) begin
            olf_q <= 1'b0;
         end else if (ctrl_q.pulsed_limit_bit) begin
            olf_q <= overload_s;
         end else if (ol_q == lsc_pkg::OL_NORMAL) begin
            olf_q <= overload_s & ~otf_q;
         end else if (ol_q == lsc_pkg::OL_ON && tmr_zero &&
                      !(seen_q | overload_s)) begin
            olf_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // power stage controls
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         POWER <= '0;
      end else if (CE) begin
         POWER.power_on <= ctrl_q.enable_bit & ~otf_q &
                           (ol_q != lsc_pkg::OL_OFF);
         POWER.volt_high <= ctrl_q.enable_bit &
                            ctrl_q.voltage_select_bit;
         POWER.line_comp <= ctrl_q.enable_bit &
                            ctrl_q.line_drop_comp_bit;
         POWER.static_clamp <= ctrl_q.pulsed_limit_bit;
      end
   end

   // ------------------------------------------------------------
   // tone path and keying
   // ------------------------------------------------------------
   // stand-by gates the path even if the pin is left high
   assign path_on = ctrl_q.enable_bit &
                    (path_pin_s | ctrl_q.tone_path_bit);

   // free running half-period divider for the carrier
   always_ff @(posedge CLK) begin
      if (RST) begin
         half_q <= '0;
      end else if (CE) begin
         half_q <= (half_q == '0) ? HALF_LOAD : half_q - 1'b1;
      end
   end

   assign half_tick = (half_q == '0);

   // keying sequencer: half a cycle to start, one cycle to stop
   always_ff @(posedge CLK) begin
      if (RST) begin
         tg_q <= lsc_pkg::TG_IDLE;
      end else if (CE) begin
         if (~path_on) begin
            tg_q <= lsc_pkg::TG_IDLE;
         end else begin
            unique case (tg_q)
               lsc_pkg::TG_IDLE: begin
                  if (gate_s) begin
                     tg_q <= lsc_pkg::TG_START;
                  end
               end
               lsc_pkg::TG_START: begin
                  if (~gate_s) begin
                     tg_q <= lsc_pkg::TG_IDLE;
                  end else if (half_tick) begin
                     tg_q <= lsc_pkg::TG_RUN;
                  end
               end
               lsc_pkg::TG_RUN: begin
                  if (~gate_s) begin
                     tg_q <= lsc_pkg::TG_STOP;
                  end
               end
               lsc_pkg::TG_STOP: begin
                  if (gate_s) begin
                     tg_q <= lsc_pkg::TG_RUN;
                  end else if (half_tick && halves_q == 2'h1) begin
                     tg_q <= lsc_pkg::TG_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // counts half periods of the stop tail
   always_ff @(posedge CLK) begin
      if (RST) begin
         halves_q <= 2'h0;
      end else if (CE) begin
         if (tg_q != lsc_pkg::TG_STOP) begin
            halves_q <= 2'h0;
         end else if (half_tick) begin
            halves_q <= halves_q + 2'h1;
         end
      end
   end

   assign tone_req = (tg_q == lsc_pkg::TG_RUN) |
                     (tg_q == lsc_pkg::TG_STOP) |
                     ctrl_q.continuous_tone_bit;
   assign tone_gen = path_on & tone_req;

   // square carrier, held low while keyed off
   always_ff @(posedge CLK) begin
      if (RST) begin
         tone_q <= 1'b0;
      end else if (CE) begin
         if (~tone_gen) begin
            tone_q <= 1'b0;
         end else if (half_tick) begin
            tone_q <= ~tone_q;
         end
      end
   end

   // pull-down follows tone generation, registered for clean edges
   always_ff @(posedge CLK) begin
      if (RST) begin
         PULLDOWN_CONTROL_OUT <= 1'b0;
         TONE_PATH_ON <= 1'b0;
      end else if (CE) begin
         PULLDOWN_CONTROL_OUT <= tone_gen;
         TONE_PATH_ON <= path_on;
      end
   end

   assign TONE_OUT = tone_q;
endmodule
`default_nettype wire

//--- verif/lsc_host_tone.sv
// host side model driving the tone gate and tone path pins
`default_nettype none
module lsc_host_tone (
   input wire logic key_req,
   input wire logic path_req,
   output logic tone_gate_input,
   output logic tone_path_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lnk_clk;
   // own 320 ns clock, phase unrelated to the system clock
   initial begin
      lnk_clk = 1'b0;
      tone_gate_input = 1'b0;
      tone_path_enable = 1'b0;
      #37;
      forever #160 lnk_clk = ~lnk_clk;
   end
   // pins move only on the host clock; gate never keyed without a path
   always @(posedge lnk_clk) begin
      tone_path_enable <= path_req;
      tone_gate_input <= key_req & path_req;
   end
endmodule
`default_nettype wire

//--- verif/lsc_supply_props.sv
// concurrent checks on the supply control ports
`default_nettype none
module lsc_supply_props #(
   parameter int unsigned OFF_CYC = 100,
   parameter int unsigned ON_CYC = 10
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic OVERLOAD_DET,
   input wire logic OVER_TEMP_DET,
   input wire lsc_pkg::lsc_power_s POWER,
   input wire logic TONE_OUT,
   input wire logic PULLDOWN_CONTROL_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] gap_q;
   logic run_q;
   logic ack;
   assign ack = AVS_READ && !AVS_WAITREQUEST;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // cycles since the last tone edge
   always_ff @(posedge CLK) begin
      if (RST || $changed(TONE_OUT)) begin
         gap_q <= 10'h001;
      end else begin
         gap_q <= gap_q + 10'h001;
      end
   end
   // first edge of a burst has no fixed spacing, so only count inside one
   always_ff @(posedge CLK) begin
      if (RST || !PULLDOWN_CONTROL_OUT) begin
         run_q <= 1'b0;
      end else if ($changed(TONE_OUT)) begin
         run_q <= 1'b1;
      end
   end
   wait_one_a: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("access not answered after one wait state");
   read_upper_a: assert property (
      ack |-> AVS_READDATA[31:5] == 27'h0)
      else $error("upper read bits not zero");
   rd_hold_a: assert property (
      !AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data moved without a read");
   ot_clear_a: assert property (
      !OVER_TEMP_DET [*6] ##0 ack |-> !AVS_READDATA[4])
      else $error("over-temperature flag set without cause");
   ot_flag_a: assert property (
      OVER_TEMP_DET [*6] |-> !POWER.power_on && (!ack || AVS_READDATA[4]))
      else $error("over-temperature did not shut off or flag");
   static_flag_a: assert property (
      (POWER.static_clamp && POWER.power_on && OVERLOAD_DET) [*6] ##0 ack
      |-> AVS_READDATA[3])
      else $error("clamp overload not flagged");
   pdc_tone_a: assert property (
      $changed(TONE_OUT) |-> PULLDOWN_CONTROL_OUT
      || $past(PULLDOWN_CONTROL_OUT))
      else $error("tone moved with pull-down idle");
   // a keyed-off tail forces the carrier low off the divider tick,
   // so only edges with the pull-down still up are real half periods
   tone_half_a: assert property (
      $changed(TONE_OUT) && run_q && PULLDOWN_CONTROL_OUT
      |-> gap_q == lsc_pkg::TONE_HALF_CYC)
      else $error("tone half period wrong");
endmodule
bind lsc_supply_ctrl lsc_supply_props #(.OFF_CYC(OFF_CYC), .ON_CYC(ON_CYC))
   u_props (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .OVERLOAD_DET(OVERLOAD_DET),
   .OVER_TEMP_DET(OVER_TEMP_DET), .POWER(POWER), .TONE_OUT(TONE_OUT),
   .PULLDOWN_CONTROL_OUT(PULLDOWN_CONTROL_OUT));
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the supply control block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ON = 10;
   typedef struct packed {
      logic [7:0] wv;
      logic [7:0] rv;
      logic [3:0] pv;
   } lsc_tbrow_s;
   localparam lsc_tbrow_s ROWS [6] = '{'{8'h00, 8'h00, 4'h0},
      '{8'h01, 8'h01, 4'h8}, '{8'h03, 8'h03, 4'hC}, '{8'h05, 8'h05, 4'hA},
      '{8'h0F, 8'h07, 4'hF}, '{8'h07, 8'h07, 4'hE}};
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hF;
   logic ol = 1'b0;
   logic ot = 1'b0;
   logic key = 1'b0;
   logic path = 1'b0;
   logic [31:0] rdat;
   logic wreq, gate, pin, path_on, tone, pulldown_control_out;
   lsc_pkg::lsc_power_s pw;
   logic [31:0] got;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cnt;
   lsc_supply_ctrl #(.OFF_CYC(100), .ON_CYC(ON)) u_lsc_supply_ctrl (
      .CLK(CLK), .RST(RST), .CE(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .OVERLOAD_DET(ol),
      .OVER_TEMP_DET(ot), .TONE_GATE_INPUT(gate), .TONE_PATH_ENABLE(pin),
      .POWER(pw), .TONE_PATH_ON(path_on), .TONE_OUT(tone),
      .PULLDOWN_CONTROL_OUT(pulldown_control_out));
   lsc_host_tone u_lsc_host_tone (.key_req(key), .path_req(path),
      .tone_gate_input(gate), .tone_path_enable(pin));
   // free-running system clock
   initial begin
      forever #20 CLK = ~CLK;
   end
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // one bus access held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      int i;
      i = 0;
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      // no cycle count assumed here; only the watchdog ends a hang
      do begin
         @(posedge CLK);
         i++;
      end while (wreq !== 1'b0);
      chk("wait states", 32'h1, i - 1);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic wreg(input logic [7:0] d);
      bus(1'b1, 4'h0, {24'h0, 2'h0, d[5:0]});
   endtask
   task automatic rbit(input int b, input logic v, input string what);
      bus(1'b0, 4'h0, 32'h0);
      chk(what, {31'h0, v}, {31'h0, got[b]});
   endtask
   task automatic span(input logic lvl, output int n);
      n = 0;
      while (pw.power_on === lvl && n < 5000) begin
         @(posedge CLK);
         n++;
      end
   endtask
   task automatic wait_pdc(input logic lvl, input int lim, input string s);
      int n;
      n = 0;
      while (pulldown_control_out !== lvl && n < lim) begin
         @(posedge CLK);
         n++;
      end
      chk(s, {31'h0, lvl}, {31'h0, pulldown_control_out});
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run of about 5000 cycles
   initial begin
      repeat (40000) @(posedge CLK);
      n_mismatch++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      chk("power at reset", 32'h0, {28'h0, pw});
      rbit(3, 1'b0, "overload flag at reset");
      foreach (ROWS[k]) begin
         wreg(ROWS[k].wv);
         repeat (4) @(posedge CLK);
         chk("power", {28'h0, ROWS[k].pv}, {28'h0, pw});
         bus(1'b0, 4'h0, 32'h0);
         chk("readback", {24'h0, ROWS[k].rv}, got);
      end
      $display("test settings done");
      // zero data, so a write that landed would drop the enable
      bus(1'b1, 4'h4, 32'h00);
      be <= 4'h0;
      wreg(8'h00);
      be <= 4'hF;
      bus(1'b0, 4'h4, 32'h0);
      chk("unmapped read", 32'h0, got);
      rbit(0, 1'b1, "enable kept");
      $display("test refusals done");
      wreg(8'h09);
      ol <= 1'b1;
      repeat (8) @(posedge CLK);
      chk("clamp power", 32'h1, {31'h0, pw.power_on});
      rbit(3, 1'b1, "clamp flag");
      ol <= 1'b0;
      repeat (8) @(posedge CLK);
      rbit(3, 1'b0, "clamp flag clear");
      $display("test static clamp done");
      wreg(8'h01);
      ol <= 1'b1;
      span(1'b1, cnt);
      span(1'b0, cnt);
      chk("off interval", 32'd100, cnt);
      span(1'b1, cnt);
      chk("on interval", ON, cnt);
      rbit(3, 1'b1, "pulsed flag");
      ol <= 1'b0;
      span(1'b0, cnt);
      repeat (ON + 8) @(posedge CLK);
      chk("resumed power", 32'h1, {31'h0, pw.power_on});
      rbit(3, 1'b0, "pulsed flag clear");
      $display("test pulsed limit done");
      ot <= 1'b1;
      repeat (8) @(posedge CLK);
      rbit(4, 1'b1, "temp flag");
      ot <= 1'b0;
      repeat (8) @(posedge CLK);
      chk("temp power", 32'h1, {31'h0, pw.power_on});
      rbit(4, 1'b0, "temp flag clear");
      $display("test over-temperature done");
      path <= 1'b1;
      key <= 1'b1;
      wait_pdc(1'b1, 600, "tone start");
      chk("path on", 32'h1, {31'h0, path_on});
      repeat (3000) @(posedge CLK);
      key <= 1'b0;
      wait_pdc(1'b0, 1200, "tone stop");
      path <= 1'b0;
      wreg(8'h31);
      wait_pdc(1'b1, 600, "continuous tone");
      wreg(8'h01);
      wait_pdc(1'b0, 1200, "continuous stop");
      $display("test tone done");
      wreg(8'h07);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      chk("power after reset", 32'h0, {28'h0, pw});
      bus(1'b0, 4'h0, 32'h0);
      chk("readback after reset", 32'h0, got);
      wreg(8'h00);
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
